/* include/sbc_consts.svh */
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
// register byte offsets
`define SBC_OFF_CTRL   12'h000
`define SBC_OFF_STAT   12'h004
`define SBC_OFF_OSC_SETTLE_TIME_SELECT   12'h008
`define SBC_OFF_PERIPH 12'h00c
// ctrl register bits (write one = pulse)
`define SBC_CTRL_HALT  0
`define SBC_CTRL_STOP  1
// periph config bits
`define SBC_CFG_T8A_EXT  0
`define SBC_CFG_T8B_EXT  1
`define SBC_CFG_WT_SUB   2
`define SBC_CFG_CLKO_SUB 3
`define SBC_CFG_SER_EXT  4
`define SBC_CFG_EXTBUS   5
`define SBC_CFG_MAINCLK  6
`define SBC_CFG_SUBPRES  7
`define SBC_CFG_W        8
// settle select reset value and field width
`define SBC_OSC_SETTLE_TIME_SELECT_RST   3'h4
`define SBC_OSC_SETTLE_TIME_SELECT_W     3
// settle counts: 2^(12+2*sel) main clock cycles, sel 0..3; sel 4 and above give 2^18 (counter width)
`define SBC_SETTLE_BASE 5'h0c
`define SBC_CNT_W       18
`endif

/* include/sbc_pkg.sv */
package sbc_pkg;
  // standby state, one-hot
  typedef enum logic [3:0] {
    SBC_RUN    = 4'h1,
    SBC_HALT   = 4'h2,
    SBC_STOP   = 4'h4,
    SBC_SETTLE = 4'h8
  } sbc_state_e;
  // release outcome toward the cpu
  typedef struct packed {
    logic vector_irq; // take vectored service
    logic next_instr; // continue at next instruction
    logic reset_req;  // reset processing
  } sbc_resume_s;
  // peripheral gating outputs
  typedef struct packed {
    logic cpu_clk_en;
    logic t16_run;
    logic t8a_run;
    logic t8b_run;
    logic wt_run;
    logic wdt_run;
    logic clko_run;
    logic clko_low;
    logic buz_low;
    logic adc_run;
    logic ser_run;
    logic uart_run;
    logic x2_pullup;
    logic main_osc_en;
  } sbc_gate_s;
endpackage : sbc_pkg

/* logic/sbc_release.sv */
`timescale 1ns/1ps
`include "sbc_consts.svh"
// decides what an interrupt does to a standby mode
module sbc_release (
  input  wire logic     irq_pending,              // request flag set
  input  wire logic     interrupt_mask_flag,      // mask of that request
  input  wire logic     interrupt_priority_flag,  // 1 = low priority
  input  wire logic     global_interrupt_enable,
  input  wire logic     in_service_priority_flag,
  input  wire logic     nmi_req,
  output logic          wake,                     // leave standby
  output logic          service                   // vectored service
);
  logic unmasked;
  always_comb begin
    unmasked = irq_pending & ~interrupt_mask_flag;
    wake = unmasked | nmi_req;
    // low priority needs enable and isp
    if (nmi_req) begin
      service = 1'b1;
    end else if (!interrupt_priority_flag) begin
      service = unmasked & global_interrupt_enable;
    end else begin
      service = unmasked & global_interrupt_enable & in_service_priority_flag;
    end
  end
endmodule : sbc_release

/* logic/sbc_ctrl.sv */
`timescale 1ns/1ps
`include "sbc_consts.svh"
//////////////////////////////////////////////////////////////////////
// Contract
// - reset in halt restarts via vector
// - masked request keeps halt; else enable decides
// - low priority services if enable and isp
// - nmi ends halt only on main clock, always vectored
// - stop only by instruction on main clock
// - stop pulls main oscillator output up
// - pending unmasked request drops stop to halt
// - resume from stop only after selected settle wait
// - stop halts main osc and cpu, latches hold
// - 16-bit timers stop; 8-bit need external input
// - watch timer needs subclock; watchdog stops
// - clock out on subclock else low; buzzer low
// - adc stops, serial needs external clock
// - uarts stop holding their registers
// - bus: ad float, upper hold, strobes fixed
// - unmasked interrupt ends stop after settle
// - reset ends stop, then settle
module sbc_ctrl (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 reset_in,   // device reset request, level
  input  wire logic                 irq_pending,
  input  wire logic                 interrupt_mask_flag,
  input  wire logic                 interrupt_priority_flag,
  input  wire logic                 global_interrupt_enable,
  input  wire logic                 in_service_priority_flag,
  input  wire logic                 nmi_req,
  output sbc_pkg::sbc_resume_s      resume,     // one-cycle outcome pulse
  output sbc_pkg::sbc_gate_s        gate,
  output logic                      main_osc_output_pin_pu,
  output logic                      muxed_addr_data_oe_hold, // 1 = bus floated
  output logic                      upper_addr_hold,
  output logic                      addr_strobe_force_low,
  output logic                      rdwr_force_high,
  output logic                      wait_float
);
  //////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    sbc_pkg::sbc_state_e   st;
    logic [`SBC_CNT_W-1:0] cnt;      // settle counter
    logic                  svc;      // service decided at wake
    logic                  rst;      // wake by reset
    logic [`SBC_OSC_SETTLE_TIME_SELECT_W-1:0] osc_settle_time_select;    // osc_settle_time_select
    logic [`SBC_CFG_W-1:0] cfg;      // peripheral options
    sbc_pkg::sbc_resume_s  resume;
    sbc_pkg::sbc_gate_s    gate;
    logic [4:0]            bus;      // external bus pin modes, one per pin group
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } sbc_ctrl_s;
  sbc_ctrl_s r;
  sbc_ctrl_s next_r;
  logic wake;       // unmasked request or nmi release
  logic service;    // vectored service wanted
  logic [`SBC_CNT_W-1:0] settle_target;
  logic stopped;
  logic wr_ctrl;
  //////////////////////////////////////////////////////////////////////
  // release decoder
  sbc_release sbc_release_inst (
    .irq_pending              (irq_pending),
    .interrupt_mask_flag      (interrupt_mask_flag),
    .interrupt_priority_flag  (interrupt_priority_flag),
    .global_interrupt_enable  (global_interrupt_enable),
    .in_service_priority_flag (in_service_priority_flag),
    .nmi_req                  (nmi_req & r.cfg[`SBC_CFG_MAINCLK]),
    .wake                     (wake),
    .service                  (service)
  );
  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r = r;
    next_r.resume = '0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    wr_ctrl = 1'b0;
    // settle length from select field; out-of-range selects longest
    settle_target = (r.osc_settle_time_select > `SBC_OSC_SETTLE_TIME_SELECT_RST) ? {`SBC_CNT_W{1'b1}} :
      `SBC_CNT_W'((`SBC_CNT_W'(1) << (`SBC_SETTLE_BASE + 5'(r.osc_settle_time_select) + 5'(r.osc_settle_time_select))) - 1);
    // apb: one wait state, pready registered from the first access cycle
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      case (paddr)
        `SBC_OFF_CTRL: begin
          wr_ctrl = pwrite;
        end
        `SBC_OFF_STAT: begin
          next_r.prdata = {28'h0000000, r.st};
        end
        `SBC_OFF_OSC_SETTLE_TIME_SELECT: begin
          if (pwrite) begin
            next_r.osc_settle_time_select = pwdata[`SBC_OSC_SETTLE_TIME_SELECT_W-1:0];
          end
          next_r.prdata = {29'h0000000, r.osc_settle_time_select};
        end
        `SBC_OFF_PERIPH: begin
          if (pwrite) begin
            next_r.cfg = pwdata[`SBC_CFG_W-1:0];
          end
          next_r.prdata = {24'h000000, r.cfg};
        end
        default: begin
          // unmapped address
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    case (r.st)
      sbc_pkg::SBC_RUN: begin
        if (wr_ctrl && pwdata[`SBC_CTRL_STOP] && r.cfg[`SBC_CFG_MAINCLK]) begin
          // pending request falls back to halt
          if (irq_pending && !interrupt_mask_flag) begin
            next_r.st = sbc_pkg::SBC_HALT;
          end else begin
            // stop by instruction on main clock
            next_r.st = sbc_pkg::SBC_STOP;
          end
        end else if (wr_ctrl && pwdata[`SBC_CTRL_HALT]) begin
          next_r.st = sbc_pkg::SBC_HALT;
        end
      end
      sbc_pkg::SBC_HALT: begin
        if (reset_in) begin
          // reset ends halt via reset vector
          next_r.resume.reset_req = 1'b1;
          next_r.st = sbc_pkg::SBC_RUN;
        end else if (wake) begin
          // halt keeps main osc running, no settle wait
          next_r.resume.vector_irq = service;
          next_r.resume.next_instr = ~service;
          next_r.st = sbc_pkg::SBC_RUN;
        end
      end
      sbc_pkg::SBC_STOP: begin
        if (reset_in) begin
          next_r.rst = 1'b1;
          next_r.cnt = '0;
          next_r.st = sbc_pkg::SBC_SETTLE;
        end else if (irq_pending && !interrupt_mask_flag) begin
          next_r.rst = 1'b0;
          next_r.svc = service;
          next_r.cnt = '0;
          next_r.st = sbc_pkg::SBC_SETTLE;
        end
      end
      sbc_pkg::SBC_SETTLE: begin
        next_r.cnt = r.cnt + `SBC_CNT_W'(1);
        if (r.cnt >= settle_target) begin
          next_r.resume.reset_req = r.rst;
          next_r.resume.vector_irq = ~r.rst & r.svc;
          next_r.resume.next_instr = ~r.rst & ~r.svc;
          next_r.st = sbc_pkg::SBC_RUN;
        end
      end
      default: begin
        next_r.st = sbc_pkg::SBC_RUN;
      end
    endcase
    stopped = (next_r.st == sbc_pkg::SBC_STOP);
    // main osc and cpu halt, latches untouched
    next_r.gate.main_osc_en = ~stopped;
    next_r.gate.cpu_clk_en = (next_r.st == sbc_pkg::SBC_RUN);
    next_r.gate.x2_pullup = stopped;
    next_r.gate.t16_run = ~stopped;
    next_r.gate.t8a_run = ~stopped | r.cfg[`SBC_CFG_T8A_EXT];
    next_r.gate.t8b_run = ~stopped | r.cfg[`SBC_CFG_T8B_EXT];
    next_r.gate.wt_run = ~stopped | (r.cfg[`SBC_CFG_WT_SUB] & r.cfg[`SBC_CFG_SUBPRES]);
    next_r.gate.wdt_run = ~stopped;
    next_r.gate.clko_run = ~stopped | (r.cfg[`SBC_CFG_CLKO_SUB] & r.cfg[`SBC_CFG_SUBPRES]);
    next_r.gate.clko_low = ~next_r.gate.clko_run;
    next_r.gate.buz_low = stopped;
    next_r.gate.adc_run = ~stopped;
    next_r.gate.ser_run = ~stopped | r.cfg[`SBC_CFG_SER_EXT];
    // uart clock stops so registers hold
    next_r.gate.uart_run = ~stopped;
    next_r.bus = {5{stopped & r.cfg[`SBC_CFG_EXTBUS]}};
  end
  //////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: sbc_pkg::SBC_RUN, cnt: '0, svc: 1'b0, rst: 1'b0,
             osc_settle_time_select: `SBC_OSC_SETTLE_TIME_SELECT_RST, cfg: '0, resume: '0,
             gate: '{cpu_clk_en: 1'b1, t16_run: 1'b1, t8a_run: 1'b1, t8b_run: 1'b1,
                     wt_run: 1'b1, wdt_run: 1'b1, clko_run: 1'b1, clko_low: 1'b0,
                     buz_low: 1'b0, adc_run: 1'b1, ser_run: 1'b1, uart_run: 1'b1,
                     x2_pullup: 1'b0, main_osc_en: 1'b1},
             bus: '0, prdata: '0, pready: 1'b0, pslverr: 1'b0};
    end else begin
      r <= next_r;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign resume = r.resume;
  assign gate = r.gate;
  assign main_osc_output_pin_pu = r.gate.x2_pullup;
  assign muxed_addr_data_oe_hold = r.bus[0];
  assign upper_addr_hold = r.bus[1];
  assign addr_strobe_force_low = r.bus[2];
  assign rdwr_force_high = r.bus[3];
  assign wait_float = r.bus[4];
  //////////////////////////////////////////////////////////////////////
  // checks
  // clocking and pull-up while stopped
  a_stop_clk_off: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> !r.gate.main_osc_en && !r.gate.cpu_clk_en)
    else $error("main osc running in stop");
  a_stop_pullup: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> r.gate.x2_pullup)
    else $error("pull-up missing in stop");
  // halt release outcomes
  a_halt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_HALT && reset_in |=> r.resume.reset_req)
    else $error("reset did not end halt");
  a_halt_masked: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_HALT && !reset_in && !nmi_req && interrupt_mask_flag
    |=> r.st == sbc_pkg::SBC_HALT)
    else $error("masked request left halt");
  a_halt_prio0: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_HALT && !reset_in && !nmi_req && irq_pending
    && !interrupt_mask_flag && !interrupt_priority_flag
    |=> r.resume.vector_irq == $past(global_interrupt_enable))
    else $error("high priority release wrong");
  a_low_prio: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_HALT && !reset_in && !nmi_req && irq_pending
    && !interrupt_mask_flag && interrupt_priority_flag && !in_service_priority_flag
    |=> r.resume.next_instr)
    else $error("low priority serviced wrongly");
  a_nmi_vector: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_HALT && !reset_in && nmi_req && r.cfg[`SBC_CFG_MAINCLK]
    |=> r.resume.vector_irq)
    else $error("nmi not vectored");
  // stop entry
  a_stop_entry: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_RUN ##1 r.st == sbc_pkg::SBC_STOP
    |-> $past(wr_ctrl) && $past(r.cfg[`SBC_CFG_MAINCLK]))
    else $error("stop without instruction");
  a_stop_pending: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> !$past(irq_pending && !interrupt_mask_flag)
    || $past(r.st) == sbc_pkg::SBC_STOP)
    else $error("stop entered with pending request");
  // gating in stop follows the options held one cycle earlier
  a_wdt_stop: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> !r.gate.wdt_run && !r.gate.t16_run
    && r.gate.buz_low && !r.gate.adc_run && !r.gate.uart_run)
    else $error("peripheral running in stop");
  a_t8_ext: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> r.gate.t8a_run == $past(r.cfg[`SBC_CFG_T8A_EXT])
    && r.gate.t8b_run == $past(r.cfg[`SBC_CFG_T8B_EXT]))
    else $error("8-bit timer gating wrong in stop");
  a_watch_sub: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP
    |-> r.gate.wt_run == $past(r.cfg[`SBC_CFG_WT_SUB] && r.cfg[`SBC_CFG_SUBPRES]))
    else $error("watch timer gating wrong in stop");
  a_clkout_sub: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> r.gate.clko_low == !r.gate.clko_run
    && r.gate.clko_run == $past(r.cfg[`SBC_CFG_CLKO_SUB] && r.cfg[`SBC_CFG_SUBPRES]))
    else $error("clock out wrong in stop");
  a_serial_ext: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> !r.gate.adc_run
    && r.gate.ser_run == $past(r.cfg[`SBC_CFG_SER_EXT]))
    else $error("serial gating wrong in stop");
  a_uart_hold: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> !r.gate.uart_run && !r.gate.cpu_clk_en)
    else $error("uart clock running in stop");
  a_bus_modes: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP |-> r.bus == {5{$past(r.cfg[`SBC_CFG_EXTBUS])}})
    else $error("bus pin modes wrong in stop");
  // release from stop and the settle wait
  a_stop_wake: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP && !reset_in && irq_pending && !interrupt_mask_flag
    |=> r.st == sbc_pkg::SBC_SETTLE && r.svc == $past(service))
    else $error("interrupt did not end stop");
  a_stop_reset: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_STOP && reset_in |=> r.st == sbc_pkg::SBC_SETTLE && r.rst)
    else $error("reset did not end stop");
  a_settle_wait: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_SETTLE && r.cnt < settle_target |=> !r.gate.cpu_clk_en)
    else $error("cpu resumed before settle");
  a_settle_done: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == sbc_pkg::SBC_SETTLE && r.cnt >= settle_target
    |=> r.st == sbc_pkg::SBC_RUN && r.gate.cpu_clk_en)
    else $error("cpu clock not restored after settle");
endmodule : sbc_ctrl

/* sim/sbc_irq_src.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
// interrupt controller stand-in: flag levels move just after an edge
module sbc_irq_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] cmd,     // pend mask prio ie isp nmi
  input  wire logic       on_main, // cpu runs on main clock
  output logic      [5:0] flags
);
  // registered, so a flag never changes on the sampling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle with the request masked
      flags <= 6'h10;
    end else begin
      flags <= {cmd[5:1], cmd[0] & on_main};
    end
  end
endmodule : sbc_irq_src

/* sim/tb_standby_halt_stop_control.sv */
`timescale 1ns/1ps
`include "sbc_consts.svh"
module tb_standby_halt_stop_control;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reset_in = 1'b0;
  logic        on_main = 1'b0;   // mirrors periph bit 6
  logic [5:0]  cmd = 6'h10;      // pend mask prio ie isp nmi
  logic [5:0]  flags;
  wire  [5:0]  bus;              // pullup and the five bus controls
  sbc_pkg::sbc_resume_s resume;
  sbc_pkg::sbc_gate_s   gate;
  int          errors = 0;
  int          tests_run = 0;
  // halt table: mask prio ie isp nmi, then vector next reset
  logic [7:0]  tbl [7] = '{8'h02, 8'h24, 8'h52, 8'h62, 8'h74, 8'hb0, 8'h8c};

  always #2.5 pclk = ~pclk;

  sbc_irq_src sbc_irq_src_inst (.pclk(pclk), .presetn(presetn), .cmd(cmd),
    .on_main(on_main), .flags(flags));
  sbc_ctrl sbc_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_in(reset_in), .irq_pending(flags[5]),
    .interrupt_mask_flag(flags[4]), .interrupt_priority_flag(flags[3]),
    .global_interrupt_enable(flags[2]), .in_service_priority_flag(flags[1]),
    .nmi_req(flags[0]), .resume(resume), .gate(gate), .main_osc_output_pin_pu(bus[5]),
    .muxed_addr_data_oe_hold(bus[4]), .upper_addr_hold(bus[3]),
    .addr_strobe_force_low(bus[2]), .rdwr_force_high(bus[1]), .wait_float(bus[0]));

  //////////////////////////////////////////////////////////////////////
  // one compare for every kind of value
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // apb transfer: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n < 50, 1'b1, "pready timeout");
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    check(rd, exp, what);
  endtask : rd_check

  // waits a bounded span for the one-cycle outcome pulse
  task automatic wait_resume(input int lim, output logic [2:0] r, output int cyc);
    cyc = 0;
    r = 3'h0;
    while (r === 3'h0 && cyc < lim) begin
      @(posedge pclk);
      cyc++;
      r = resume;
    end
  endtask : wait_resume

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] rd;
    logic        er;
    rd_check(`SBC_OFF_OSC_SETTLE_TIME_SELECT, 32'h4, "osc_settle_time_select reset");
    rd_check(`SBC_OFF_STAT, 32'h1, "run after reset");
    check(gate, 32'h3f9d, "gates running");
    apb(1'b0, 12'h0f0, 32'h0, rd, er);
    check(er, 1'b1, "unmapped refused");
  endtask : t_reset

  // every halt release case, masked case left by reset
  task automatic t_halt;
    logic [2:0] r;
    int         cyc;
    wr(`SBC_OFF_PERIPH, 32'h40);
    on_main <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      // nmi comes only with the release, else halt would end at once
      cmd <= {1'b0, tbl[i][7:4], 1'b0};
      wr(`SBC_OFF_CTRL, 32'h1);
      rd_check(`SBC_OFF_STAT, 32'h2, "halt entered");
      cmd <= {1'b1, tbl[i][7:3]};
      wait_resume(20, r, cyc);
      check(r, tbl[i][2:0], "halt outcome");
      if (tbl[i][2:0] === 3'h0) begin
        reset_in <= 1'b1;
        wait_resume(20, r, cyc);
        check(r, 3'h1, "reset ends halt");
        reset_in <= 1'b0;
      end
      cmd <= 6'h10;
      rd_check(`SBC_OFF_STAT, 32'h1, "back to run");
    end
  endtask : t_halt

  // stop refused while the cpu is on the subclock
  task automatic t_stop_refused;
    wr(`SBC_OFF_PERIPH, 32'hbf);
    on_main <= 1'b0;
    wr(`SBC_OFF_CTRL, 32'h2);
    rd_check(`SBC_OFF_STAT, 32'h1, "stop refused");
  endtask : t_stop_refused

  // stop gating, then release by interrupt after settle
  task automatic t_stop(input logic [7:0] cfg, input logic [13:0] g, input logic [5:0] b,
                        input logic ie);
    logic [2:0] r;
    int         cyc;
    wr(`SBC_OFF_PERIPH, {24'h0, cfg});
    on_main <= 1'b1;
    wr(`SBC_OFF_OSC_SETTLE_TIME_SELECT, 32'h0);
    wr(`SBC_OFF_CTRL, 32'h2);
    rd_check(`SBC_OFF_STAT, 32'h4, "stop entered");
    check(gate, g, "stop gates");
    check(bus, b, "pullup and bus");
    cmd <= {3'h4, ie, 2'h0};
    wait_resume(5000, r, cyc);
    check(r, {ie, ~ie, 1'b0}, "stop outcome");
    check(cyc >= 4096 && cyc <= 4110, 1'b1, "settle length");
    cmd <= 6'h10;
    rd_check(`SBC_OFF_STAT, 32'h1, "run after settle");
    check(gate, 32'h3f9d, "gates restored");
  endtask : t_stop

  // a pending unmasked request drops stop at once
  task automatic t_stop_pending;
    logic [31:0] rd;
    logic        er;
    logic [2:0]  r;
    int          cyc;
    wr(`SBC_OFF_PERIPH, 32'h40);
    cmd <= 6'h20;
    wr(`SBC_OFF_CTRL, 32'h2);
    // the fallback halt ends one cycle later, so catch that pulse first
    wait_resume(4, r, cyc);
    check(r, 3'h2, "pending outcome");
    check(cyc, 32'h1, "no settle on fallback");
    cmd <= 6'h10;
    apb(1'b0, `SBC_OFF_STAT, 32'h0, rd, er);
    check(rd[2], 1'b0, "stop not held");
  endtask : t_stop_pending

  // reset in stop waits out the settle time
  task automatic t_stop_reset;
    logic [2:0] r;
    int         cyc;
    wr(`SBC_OFF_CTRL, 32'h2);
    rd_check(`SBC_OFF_STAT, 32'h4, "stop again");
    reset_in <= 1'b1;
    wait_resume(5000, r, cyc);
    check(r, 3'h1, "reset ends stop");
    check(cyc >= 4096, 1'b1, "reset settle");
    reset_in <= 1'b0;
  endtask : t_stop_reset

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_halt;
    t_stop_refused;
    t_stop(8'hff, 14'h0eaa, 6'h3f, 1'b1);
    t_stop(8'h40, 14'h0062, 6'h20, 1'b0);
    t_stop_pending;
    t_stop_reset;
    complete_run;
  end

  // watchdog: 40000 cycles, about three times the three 4096-cycle settle waits
  initial begin
    #200000;
    errors++;
    complete_run;
  end
endmodule : tb_standby_halt_stop_control
